// >>> hw/twi_slave_irq_status_regs.sv
// Purpose: Interrupt mask, status clear, parameter and revision registers.
// Assumes: One instance per slave interface, each on its own clock.
// Notes: Ready levels come in directly; other events are one-cycle pulses.
//
// The implementer's own choice: register access over AHB-Lite.
`timescale 1ns/1ps
module twi_slave_irq_status_regs (
    // Clock and reset
    input  wire logic        clk_sys,
    input  wire logic        sys_rst,
    // AHB-Lite slave
    input  wire logic        hsel,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] haddr,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic [31:0]      hrdata,
    output logic             hreadyout,
    output logic             hresp,
    // Status events from the slave engine
    input  wire logic [31:0] status_events,
    input  wire logic        tx_buffer_ready,
    input  wire logic        rx_buffer_ready,
    // Interrupt
    output logic             irq
);
    twi_irq_pkg::bus_req_s req;
    logic [31:0] interrupt_mask_r;
    logic [31:0] status_flags;
    logic [31:0] clear_req;
    logic        wr_en;
    logic        rd_en;

    // Variant sits in bits 19:16 and version in bits 11:0; the rest is zero.
    localparam logic [31:0] REVISION_WORD = {12'h000,
        twi_irq_pkg::VARIANT_VALUE, 4'h0, twi_irq_pkg::REVISION_VALUE};

    // Each instance has its own clk_sys; no shared state exists.
    twi_bus_slave u_bus (
        .clk_sys (clk_sys),
        .sys_rst (sys_rst),
        .hsel    (hsel),
        .htrans  (htrans),
        .hwrite  (hwrite),
        .haddr   (haddr[7:0]),
        .hready  (hready),
        .req     (req)
    );

    assign wr_en = req.sel && req.write;
    assign rd_en = req.sel && !req.write;
    // Zeros never clear: only ones on clearable positions act.
    assign clear_req = (wr_en && req.addr == twi_irq_pkg::OFS_CLEAR) ?
                       (hwdata & twi_irq_pkg::CLEARABLE_BITS) : 32'h0000_0000;

    genvar gi;
    generate
        for (gi = 0; gi < 32; gi++) begin : g_flag
            if (twi_irq_pkg::CLEARABLE_BITS[gi]) begin : g_sticky
                twi_flag_bit u_flag (
                    .clk_sys (clk_sys),
                    .sys_rst (sys_rst),
                    .set_evt (status_events[gi]),
                    .clr_req (clear_req[gi]),
                    .flag_r  (status_flags[gi])
                );
            end else if (gi == 1) begin : g_tx
                assign status_flags[gi] = tx_buffer_ready;
            end else if (gi == 0) begin : g_rx
                assign status_flags[gi] = rx_buffer_ready;
            end else begin : g_none
                assign status_flags[gi] = 1'b0;
            end
        end
    endgenerate

    // Enable and disable are separate addresses, so one write never does both.
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            interrupt_mask_r <= twi_irq_pkg::MASK_RESET;
        end else if (wr_en && req.addr == twi_irq_pkg::OFS_ENABLE) begin
            interrupt_mask_r <= interrupt_mask_r |
                (hwdata & twi_irq_pkg::MASKABLE_BITS);
        end else if (wr_en && req.addr == twi_irq_pkg::OFS_DISABLE) begin
            interrupt_mask_r <= interrupt_mask_r &
                ~(hwdata & twi_irq_pkg::MASKABLE_BITS);
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            irq <= 1'b0;
        end else begin
            irq <= |(status_flags & interrupt_mask_r);
        end
    end

    // Read data is registered, so a read takes one wait state.
    // Loading only in that wait cycle keeps hrdata steady in the data phase.
    logic rd_pend_r;
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            rd_pend_r <= 1'b0;
            hreadyout <= 1'b1;
        end else begin
            rd_pend_r <= hready && hsel && !hwrite &&
                         htrans == twi_irq_pkg::HTRANS_NONSEQ;
            hreadyout <= !(hready && hsel && !hwrite &&
                         htrans == twi_irq_pkg::HTRANS_NONSEQ);
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            hrdata <= 32'h0000_0000;
        end else if (rd_en && rd_pend_r) begin
            unique case (req.addr)
                twi_irq_pkg::OFS_MASK:     hrdata <= interrupt_mask_r;
                twi_irq_pkg::OFS_STATUS:   hrdata <= status_flags;
                twi_irq_pkg::OFS_PARAM:
                    hrdata <= twi_irq_pkg::PARAM_VALUE;
                twi_irq_pkg::OFS_REVISION:
                    hrdata <= REVISION_WORD;
                default:                   hrdata <= 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            hresp <= 1'b0;
        end else begin
            hresp <= 1'b0;
        end
    end
endmodule

// >>> hw/twi_irq_pkg.sv
// Purpose: Constants and types for the two-wire slave interrupt register bank.
// Assumes: 32-bit AHB-Lite register access, one clock per instance.
// Notes: Offsets are byte addresses.
package twi_irq_pkg;

    localparam logic [7:0]  OFS_ENABLE   = 8'h1C;
    localparam logic [7:0]  OFS_DISABLE  = 8'h20;
    localparam logic [7:0]  OFS_MASK     = 8'h24;
    localparam logic [7:0]  OFS_CLEAR    = 8'h28;
    localparam logic [7:0]  OFS_PARAM    = 8'h2C;
    localparam logic [7:0]  OFS_REVISION = 8'h30;
    localparam logic [7:0]  OFS_STATUS   = 8'h18;

    localparam logic [31:0] CLEARABLE_BITS = 32'h00FF_71C8;
    localparam logic [31:0] READY_BITS     = 32'h0000_0003;
    localparam logic [31:0] MASKABLE_BITS  = CLEARABLE_BITS | READY_BITS;
    localparam logic [31:0] MASK_RESET     = 32'h0000_0000;
    localparam logic [31:0] PARAM_VALUE    = 32'h0000_0000;
    // Arbitrary neutral revision value.
    localparam logic [11:0] REVISION_VALUE = 12'h0A5;
    localparam logic [3:0]  VARIANT_VALUE  = 4'h0;

    localparam logic [1:0]  HTRANS_NONSEQ  = 2'h2;

    typedef struct packed {
        logic        sel;
        logic        write;
        logic [7:0]  addr;
    } bus_req_s;

endpackage

// >>> hw/twi_bus_slave.sv
// Purpose: AHB-Lite address-phase capture for the register bank.
// Assumes: Single word transfers, always OKAY, zero-wait writes and one-wait reads.
// Notes: Produces a registered data-phase request.
`timescale 1ns/1ps
module twi_bus_slave (
    // Clock and reset
    input  wire logic                 clk_sys,
    input  wire logic                 sys_rst,
    // AHB-Lite address phase
    input  wire logic                 hsel,
    input  wire logic [1:0]           htrans,
    input  wire logic                 hwrite,
    input  wire logic [7:0]           haddr,
    input  wire logic                 hready,
    // Data phase request
    output twi_irq_pkg::bus_req_s     req
);
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            req <= '0;
        end else if (hready) begin
            req.sel   <= hsel && (htrans == twi_irq_pkg::HTRANS_NONSEQ);
            req.write <= hwrite;
            req.addr  <= haddr;
        end
    end
endmodule

// >>> hw/twi_flag_bit.sv
// Purpose: One sticky status flag with write-one-to-clear.
// Assumes: Event pulses synchronous to clk_sys.
// Notes: A set in the clearing cycle wins.
`timescale 1ns/1ps
module twi_flag_bit (
    // Clock and reset
    input  wire logic clk_sys,
    input  wire logic sys_rst,
    // Control
    input  wire logic set_evt,
    input  wire logic clr_req,
    // State
    output logic      flag_r
);
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            flag_r <= 1'b0;
        end else if (set_evt) begin
            flag_r <= 1'b1;
        end else if (clr_req) begin
            flag_r <= 1'b0;
        end
    end
endmodule

// >>> bench/twi_irq_checker_assertions.sv
// Purpose: Port-level checks for the interrupt register bank.
// Assumes: Zero-wait writes and one-wait reads.
// Notes: Bound to every instance of the bank.
`timescale 1ns/1ps
module twi_irq_checker (
    // Watched ports
    input wire logic        clk_sys,
    input wire logic        sys_rst,
    input wire logic        hsel,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic [31:0] haddr,
    input wire logic [31:0] hwdata,
    input wire logic        hready,
    input wire logic [31:0] hrdata,
    input wire logic        hreadyout,
    input wire logic        hresp,
    input wire logic        irq
);
    logic       tk;
    logic       rd;
    logic       wr;
    logic [7:0] a;
    assign tk = hsel && hready && htrans == twi_irq_pkg::HTRANS_NONSEQ;
    assign rd = tk && !hwrite;
    assign wr = tk && hwrite;
    assign a  = haddr[7:0];
    default clocking @(posedge clk_sys); endclocking
    default disable iff (sys_rst);
    chk_reset_idle: assert property ($fell(sys_rst) |-> !irq)
        else $error("irq high after reset");
    chk_resp_okay: assert property (!hresp)
        else $error("error response");
    chk_read_wait: assert property (rd |=> !hreadyout ##1 hreadyout)
        else $error("read wait state wrong");
    chk_write_nowait: assert property (wr |=> hreadyout)
        else $error("write stalled");
    chk_param_zero: assert property (
        rd && a == twi_irq_pkg::OFS_PARAM |-> ##2 hrdata == 32'h00000000)
        else $error("param not zero");
    chk_rev_value: assert property (
        rd && a == twi_irq_pkg::OFS_REVISION
        |-> ##2 hrdata[11:0] == twi_irq_pkg::REVISION_VALUE)
        else $error("revision wrong");
    chk_variant_zero: assert property (
        rd && a == twi_irq_pkg::OFS_REVISION
        |-> ##2 hrdata[31:12] == 20'h00000) else $error("variant wrong");
    chk_mask_layout: assert property (
        rd && a == twi_irq_pkg::OFS_MASK
        |-> ##2 (hrdata & 32'hFF008E34) == 32'h00000000)
        else $error("mask bit");
    chk_unmapped_zero: assert property (rd && a == 8'h34
        |-> ##2 hrdata == 32'h00000000) else $error("unmapped read not zero");
    chk_disable_quiet: assert property (
        (wr && a == twi_irq_pkg::OFS_DISABLE) ##1 (hwdata == 32'hFFFFFFFF)
        |-> ##2 !irq) else $error("irq high after full disable");
endmodule
bind twi_slave_irq_status_regs twi_irq_checker chk_u (.clk_sys(clk_sys),
    .sys_rst(sys_rst), .hsel(hsel), .htrans(htrans), .hwrite(hwrite),
    .haddr(haddr), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .irq(irq));

// >>> bench/tb.sv
// Purpose: Self-checking bench for the interrupt register bank.
// Assumes: Single-slave bus, so hreadyout feeds hready.
// Notes: Expected words are built from the register bit layout.
`timescale 1ns/1ps
module tb;
    logic        clk_sys, sys_rst, hsel, hwrite, irq, hreadyout, hresp;
    logic        tx_rdy, rx_rdy;
    logic [1:0]  htrans;
    logic [31:0] haddr, hwdata, hrdata, status_events, q;
    int          n_fail, total_checks;
    twi_slave_irq_status_regs dut_u (.clk_sys(clk_sys), .sys_rst(sys_rst),
        .hsel(hsel), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
        .haddr(haddr), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .status_events(status_events), .tx_buffer_ready(tx_rdy),
        .rx_buffer_ready(rx_rdy), .irq(irq));
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    task conclude;
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // Ready is judged at the falling edge, clear of the rising-edge updates.
    task rdy;
        int i;
        for (i = 0; i < 20; i++) begin
            @(negedge clk_sys);
            if (hreadyout === 1'b1) break;
        end
        if (i == 20) begin
            n_fail++;
            conclude;
        end
        @(posedge clk_sys);
    endtask
    task addr_ph(input logic w, input logic [7:0] a);
        hsel <= 1'b1;
        htrans <= twi_irq_pkg::HTRANS_NONSEQ;
        hwrite <= w;
        haddr <= {24'h000000, a};
        rdy;
    endtask
    task data_ph(input logic [31:0] d);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        rdy;
        q = hrdata;
    endtask
    task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        addr_ph(w, a);
        data_ph(d);
    endtask
    task rd(input logic [7:0] a, input logic [31:0] e);
        xfer(1'b0, a, 32'h0);
        chk(q, e);
    endtask
    task irq_is(input logic e);
        repeat (2) @(posedge clk_sys);
        @(negedge clk_sys);
        chk({31'h0, irq}, {31'h0, e});
        @(posedge clk_sys);
    endtask
    initial begin
        {sys_rst, hsel, htrans, hwrite, haddr, hwdata} = {1'b1, 36'h0, 32'h0};
        status_events = 32'h0;
        {tx_rdy, rx_rdy, n_fail, total_checks} = {2'b10, 64'h0};
        repeat (12) @(posedge clk_sys);
        sys_rst <= 1'b0;
        @(posedge clk_sys);
        rd(twi_irq_pkg::OFS_MASK, 32'h00000000);
        rd(twi_irq_pkg::OFS_PARAM, 32'h00000000);
        rd(twi_irq_pkg::OFS_REVISION,
           {20'h0, twi_irq_pkg::REVISION_VALUE});
        rd(8'h34, 32'h0);
        $display("test reset_values done");
        xfer(1'b1, twi_irq_pkg::OFS_ENABLE, 32'hFFFFFFFF);
        rd(twi_irq_pkg::OFS_MASK, 32'h00FF71CB);
        xfer(1'b1, twi_irq_pkg::OFS_MASK, 32'h0);
        rd(twi_irq_pkg::OFS_MASK, 32'h00FF71CB);
        xfer(1'b1, twi_irq_pkg::OFS_DISABLE, 32'h00FF7000);
        rd(twi_irq_pkg::OFS_MASK, 32'h000001CB);
        xfer(1'b1, twi_irq_pkg::OFS_DISABLE, 32'hFFFFFFFF);
        $display("test mask_set_clear done");
        status_events <= 32'h00FF71C8;
        @(posedge clk_sys);
        status_events <= 32'h0;
        irq_is(1'b0);
        rd(twi_irq_pkg::OFS_STATUS, 32'h00FF71CA);
        xfer(1'b1, twi_irq_pkg::OFS_ENABLE, 32'h00000008);
        irq_is(1'b1);
        xfer(1'b1, twi_irq_pkg::OFS_CLEAR, 32'h0);
        rd(twi_irq_pkg::OFS_STATUS, 32'h00FF71CA);
        xfer(1'b1, twi_irq_pkg::OFS_CLEAR, 32'hFFFFFFFF);
        irq_is(1'b0);
        rd(twi_irq_pkg::OFS_STATUS, 32'h00000002);
        xfer(1'b1, twi_irq_pkg::OFS_ENABLE, 32'h00000002);
        irq_is(1'b1);
        xfer(1'b1, twi_irq_pkg::OFS_CLEAR, 32'hFFFFFFFF);
        irq_is(1'b1);
        // An event in the clear's data phase must survive the clear.
        addr_ph(1'b1, twi_irq_pkg::OFS_CLEAR);
        status_events <= 32'h00000088;
        data_ph(32'h00000008);
        status_events <= 32'h00000000;
        rd(twi_irq_pkg::OFS_STATUS, 32'h0000008A);
        rx_rdy <= 1'b1;
        xfer(1'b1, twi_irq_pkg::OFS_CLEAR, 32'h00000008);
        rd(twi_irq_pkg::OFS_STATUS, 32'h00000083);
        xfer(1'b1, twi_irq_pkg::OFS_DISABLE, 32'hFFFFFFFF);
        irq_is(1'b0);
        xfer(1'b1, twi_irq_pkg::OFS_ENABLE, 32'h00000080);
        irq_is(1'b1);
        $display("test irq_flow done");
        sys_rst <= 1'b1;
        repeat (2) @(posedge clk_sys);
        sys_rst <= 1'b0;
        @(posedge clk_sys);
        irq_is(1'b0);
        rd(twi_irq_pkg::OFS_STATUS, 32'h00000003);
        rd(twi_irq_pkg::OFS_MASK, 32'h00000000);
        $display("test mid_reset done");
        conclude;
    end
endmodule
